// *** logic/asr_regs.sv ***
// Behaviour
// - Status one: bits 1,2,3,4,7 from peripherals
// - Status one follows sources; no access clears
// - Status two: mouse bit 0, keyboard bit 1
// - Infrared edge sets bit 2; read clears
// - Bit 4 mirrors kbc reset line
// - Pin mux register holds five select bits
// - Pin mux resets to 0x06
// - Force-change flags: write 1 sets, 0 ignored
// - Step with drive select clears flag
// - Force-change flags reset to 0x03
// - Disk-changed bit combines selects, flags, input
// - Rate shadow: rate, write_field_a, powerdown, reset
// - Fifo shadows: enable, resets, dma, trigger
// - Location mux picks serial or alternate rx
`timescale 1ns/10ps
`include "asr_map.svh"
`default_nettype none

module asr_regs (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_b,
  // Register port
  input wire asr_pkg::asr_bus_t bus,
  output logic [7:0] rdata,
  // Peripheral sources, already on core_clk
  input wire asr_pkg::asr_src_t src,
  // Write-only source registers being written
  input wire asr_pkg::asr_shd_t shd,
  // Pins
  input wire logic serial_two_rx,
  input wire logic alt_infrared_rx,
  input wire logic ir_location_mux,
  input wire asr_pkg::asr_fdd_t fdd,
  // Results
  output logic disk_changed_bit,
  output logic [4:0] pin_mux_sel,
  output logic irq
);

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers
  logic [1:0] sx_s1_q;
  logic [1:0] sx_s2_q;
  logic [3:0] fd_s1_q;
  logic [3:0] fd_s2_q;
  logic ir_prev_q;
  logic ir_now;

  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      sx_s1_q <= 2'h3;
      sx_s2_q <= 2'h3;
      // Idle pin levels, so no step with a select is seen just after reset
      fd_s1_q <= 4'he;
      fd_s2_q <= 4'he;
    end else begin
      sx_s1_q <= {alt_infrared_rx, serial_two_rx};
      sx_s2_q <= sx_s1_q;
      fd_s1_q <= fdd;
      fd_s2_q <= fd_s1_q;
    end
  end

  // Mux after synchronising, so the edge detector sees the selected pin
  assign ir_now = ir_location_mux ? sx_s2_q[1] : sx_s2_q[0];

  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      ir_prev_q <= 1'h1;
    end else begin
      ir_prev_q <= ir_now;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Access decode
  function automatic logic hit(input logic [7:0] a, input logic [7:0] idx);
    hit = (a == idx);
  endfunction

  logic wr_mux;
  logic wr_fcr;
  logic wr_ist;
  logic wr_imsk;
  logic rd_st2;

  assign wr_mux = bus.wr && hit(bus.addr, `ASR_IDX_PIN_MUX);
  assign wr_fcr = bus.wr && hit(bus.addr, `ASR_IDX_FORCE_CHG);
  assign wr_ist = bus.wr && hit(bus.addr, `ASR_IDX_IRQ_STAT);
  assign wr_imsk = bus.wr && hit(bus.addr, `ASR_IDX_IRQ_MASK);
  assign rd_st2 = bus.rd && hit(bus.addr, `ASR_IDX_STAT_TWO);

  ////////////////////////////////////////////////////////////////////////////
  // Status registers
  logic [7:0] st_one_q;
  logic [7:0] st_two_q;
  logic ir_edge;

  assign ir_edge = ir_now ^ ir_prev_q;

  // Level bits follow their sources; no register access touches them
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      st_one_q <= 8'h00;
    end else begin
      st_one_q <= 8'h00;
      st_one_q[`ASR_BIT_PAR] <= src.parallel_irq;
      st_one_q[`ASR_BIT_SER2] <= src.serial_two_irq;
      st_one_q[`ASR_BIT_SER1] <= src.serial_one_irq;
      st_one_q[`ASR_BIT_FLOP] <= src.floppy_irq;
      st_one_q[`ASR_BIT_WDOG] <= src.watchdog_irq;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      st_two_q <= 8'h00;
    end else begin
      st_two_q[`ASR_BIT_MOUSE] <= src.mouse_irq;
      st_two_q[`ASR_BIT_KBD] <= src.keyboard_irq;
      st_two_q[`ASR_BIT_KBCRST] <= src.kbc_reset_line;
      st_two_q[3] <= 1'h0;
      st_two_q[7:5] <= 3'h0;
      // An edge in the read cycle wins, so it is never lost
      if (ir_edge) begin
        st_two_q[`ASR_BIT_IR] <= 1'h1;
      end else if (rd_st2) begin
        st_two_q[`ASR_BIT_IR] <= 1'h0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin mux and forced disk change
  logic [4:0] mux_q;
  logic [1:0] fcr_q;
  logic step_act;
  logic ds0_act;
  logic ds1_act;

  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      mux_q <= 5'(`ASR_RST_PIN_MUX);
    end else if (wr_mux) begin
      mux_q <= bus.wdata[4:0];
    end
  end

  assign pin_mux_sel = mux_q;

  // Drive pins are active low
  assign step_act = !fd_s2_q[3];
  assign ds0_act = !fd_s2_q[2];
  assign ds1_act = !fd_s2_q[1];

  // Software set beats the hardware clear in the same cycle
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      fcr_q <= `ASR_RST_FORCE_CHG;
    end else begin
      if (wr_fcr && bus.wdata[0]) begin
        fcr_q[0] <= 1'h1;
      end else if (step_act && ds0_act) begin
        fcr_q[0] <= 1'h0;
      end
      if (wr_fcr && bus.wdata[1]) begin
        fcr_q[1] <= 1'h1;
      end else if (step_act && ds1_act) begin
        fcr_q[1] <= 1'h0;
      end
    end
  end

  // Pin levels combined directly; active-low names are not inverted
  logic dchg_d;
  logic dchg_q;
  assign dchg_d = (fd_s2_q[2] & fcr_q[0]) | (fd_s2_q[1] & fcr_q[1]) | fd_s2_q[0];

  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      dchg_q <= 1'h0;
    end else begin
      dchg_q <= dchg_d;
    end
  end

  assign disk_changed_bit = dchg_q;

  ////////////////////////////////////////////////////////////////////////////
  // Shadows of write-only registers; source register itself is untouched
  logic [7:0] rate_q;
  logic [7:0] ser1_q;
  logic [7:0] ser2_q;

  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      rate_q <= `ASR_RST_SHADOW;
      ser1_q <= `ASR_RST_SHADOW;
      ser2_q <= `ASR_RST_SHADOW;
    end else begin
      if (shd.rate_wr) begin
        rate_q <= shd.data & `ASR_RATE_FIELDS;
      end
      if (shd.ser1_wr) begin
        ser1_q <= shd.data & `ASR_FCR_FIELDS;
      end
      if (shd.ser2_wr) begin
        ser2_q <= shd.data & `ASR_FCR_FIELDS;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt: sticky events, write one to clear, mask to enable
  logic [2:0] ist_q;
  logic [2:0] imsk_q;
  logic [2:0] ev;
  logic [1:0] fcr_prev_q;

  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      fcr_prev_q <= `ASR_RST_FORCE_CHG;
    end else begin
      fcr_prev_q <= fcr_q;
    end
  end

  // Infrared edge and each forced flag being cleared by a step
  assign ev = {fcr_prev_q[1] & !fcr_q[1], fcr_prev_q[0] & !fcr_q[0], ir_edge};

  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      ist_q <= 3'(`ASR_RST_IRQ);
    end else begin
      ist_q <= ev | (ist_q & ~(wr_ist ? bus.wdata[2:0] : 3'h0));
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      imsk_q <= 3'(`ASR_RST_IRQ);
    end else if (wr_imsk) begin
      imsk_q <= bus.wdata[2:0];
    end
  end

  assign irq = |(ist_q & imsk_q);

  ////////////////////////////////////////////////////////////////////////////
  // Read data, one cycle after the strobe
  logic [7:0] rdata_d;
  logic [7:0] rdata_q;

  always_comb begin
    rdata_d = 8'h00;
    case (bus.addr)
      `ASR_IDX_STAT_ONE: rdata_d = st_one_q;
      `ASR_IDX_STAT_TWO: rdata_d = st_two_q;
      `ASR_IDX_PIN_MUX: rdata_d = {3'h0, mux_q};
      `ASR_IDX_FORCE_CHG: rdata_d = {6'h00, fcr_q};
      `ASR_IDX_RATE_SHD: rdata_d = rate_q;
      `ASR_IDX_SER1_SHD: rdata_d = ser1_q;
      `ASR_IDX_SER2_SHD: rdata_d = ser2_q;
      `ASR_IDX_IRQ_STAT: rdata_d = {5'h00, ist_q};
      `ASR_IDX_IRQ_MASK: rdata_d = {5'h00, imsk_q};
      default: rdata_d = 8'h00;
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      rdata_q <= 8'h00;
    end else if (bus.rd) begin
      rdata_q <= rdata_d;
    end else begin
      rdata_q <= 8'h00;
    end
  end

  assign rdata = rdata_q;

endmodule

`default_nettype wire

// *** logic/asr_map.svh ***
`ifndef ASR_MAP_SVH
`define ASR_MAP_SVH
// Register indices
`define ASR_IDX_STAT_ONE 8'hb6
`define ASR_IDX_STAT_TWO 8'hb7
`define ASR_IDX_RSVD 8'hb8
`define ASR_IDX_PIN_MUX 8'hc0
`define ASR_IDX_FORCE_CHG 8'hc1
`define ASR_IDX_RATE_SHD 8'hc2
`define ASR_IDX_SER1_SHD 8'hc3
`define ASR_IDX_SER2_SHD 8'hc4
`define ASR_IDX_IRQ_STAT 8'hd0
`define ASR_IDX_IRQ_MASK 8'hd1
// Reset values
`define ASR_RST_PIN_MUX 8'h06
`define ASR_RST_FORCE_CHG 2'h3
`define ASR_RST_SHADOW 8'h00
`define ASR_RST_IRQ 8'h00
// Field positions and widths
`define ASR_PIN_MUX_W 5
`define ASR_FCR_FIELDS 8'hcf
`define ASR_RATE_FIELDS 8'hdf
`define ASR_BIT_PAR 1
`define ASR_BIT_SER2 2
`define ASR_BIT_SER1 3
`define ASR_BIT_FLOP 4
`define ASR_BIT_WDOG 7
`define ASR_BIT_MOUSE 0
`define ASR_BIT_KBD 1
`define ASR_BIT_IR 2
`define ASR_BIT_KBCRST 4
`define ASR_IRQ_W 3
`define ASR_IRQ_IR 0
`define ASR_IRQ_FLAG0 1
`define ASR_IRQ_FLAG1 2
`endif

// *** logic/asr_pkg.sv ***
package asr_pkg;
  typedef struct packed {
    logic parallel_irq;
    logic serial_two_irq;
    logic serial_one_irq;
    logic floppy_irq;
    logic watchdog_irq;
    logic mouse_irq;
    logic keyboard_irq;
    logic kbc_reset_line;
  } asr_src_t;

  typedef struct packed {
    logic step_pulse_out;
    logic drive_select_zero;
    logic drive_select_one;
    logic disk_changed_input;
  } asr_fdd_t;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } asr_bus_t;

  typedef struct packed {
    logic rate_wr;
    logic ser1_wr;
    logic ser2_wr;
    logic [7:0] data;
  } asr_shd_t;

  typedef struct packed {
    logic [2:0] ir_sel;
    logic ir_mode;
    logic dma3_sel;
    logic serirq_sel;
    logic kbc_sel;
    logic ir_rx3_sel;
  } asr_mux_t;
endpackage

// *** sim/asr_regs_checker.sv ***
`timescale 1ns/10ps
`default_nettype none
module asr_regs_chk (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_b,
  // Watched ports
  input wire asr_pkg::asr_bus_t bus,
  input wire logic [7:0] rdata,
  input wire asr_pkg::asr_src_t src,
  input wire asr_pkg::asr_shd_t shd,
  input wire asr_pkg::asr_fdd_t fdd,
  input wire logic disk_changed_bit,
  input wire logic [4:0] pin_mux_sel
);
  asr_pkg::asr_src_t s1_q;
  logic [7:0] ra_q;
  logic rv_q;
  // Read qualifier includes reset so a read cut short by reset is not judged
  always_ff @(posedge core_clk) begin
    s1_q <= src;
    ra_q <= bus.addr;
    rv_q <= bus.rd && rst_b;
  end
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_b);
  AST_RD_IDLE: assert property (!rv_q |-> rdata == 8'h00) else $error("rdata not idle");
  AST_STAT_ONE: assert property (rv_q && ra_q == 8'hb6 && s1_q == $past(s1_q) |->
    rdata == {s1_q.watchdog_irq, 2'b00, s1_q.floppy_irq, s1_q.serial_one_irq,
    s1_q.serial_two_irq, s1_q.parallel_irq, 1'b0}) else $error("status one");
  AST_STAT_TWO: assert property (rv_q && ra_q == 8'hb7 && s1_q == $past(s1_q) |->
    {rdata[7:3], rdata[1:0]} == {3'b000, s1_q.kbc_reset_line, 1'b0, s1_q.keyboard_irq,
    s1_q.mouse_irq}) else $error("status two");
  AST_RSVD: assert property (rv_q && ra_q == 8'hb8 |-> rdata == 8'h00) else $error("rsvd");
  AST_MUX_WR: assert property (bus.wr && bus.addr == 8'hc0 |=>
    pin_mux_sel == $past(bus.wdata[4:0])) else $error("mux write");
  AST_MUX_HOLD: assert property (!(bus.wr && bus.addr == 8'hc0) |=>
    $stable(pin_mux_sel)) else $error("mux changed");
  AST_SHD_RATE: assert property (shd.rate_wr ##1 !shd.rate_wr ##1
    (bus.rd && !shd.rate_wr && bus.addr == 8'hc2) |=>
    rdata == ($past(shd.data, 3) & 8'hdf)) else $error("rate");
  AST_SHD_SER1: assert property (shd.ser1_wr ##1 !shd.ser1_wr ##1
    (bus.rd && !shd.ser1_wr && bus.addr == 8'hc3) |=>
    rdata == ($past(shd.data, 3) & 8'hcf)) else $error("fifo");
  AST_SHD_SER2: assert property (shd.ser2_wr ##1 !shd.ser2_wr ##1
    (bus.rd && !shd.ser2_wr && bus.addr == 8'hc4) |=>
    rdata == ($past(shd.data, 3) & 8'hcf)) else $error("fifo two");
  AST_DISK_CHANGED_BIT: assert property (fdd.disk_changed_input [*5] |-> disk_changed_bit)
    else $error("disk change");
endmodule
bind asr_regs asr_regs_chk chk_i (.core_clk(core_clk), .rst_b(rst_b), .bus(bus), .rdata(rdata),
  .src(src), .shd(shd), .fdd(fdd), .disk_changed_bit(disk_changed_bit), .pin_mux_sel(pin_mux_sel));
`default_nettype wire

// *** sim/asr_periph.sv ***
`timescale 1ns/10ps
`default_nettype none
module asr_periph (
  // Clock
  input wire logic core_clk,
  // Levels the bench asks for
  input wire asr_pkg::asr_src_t src_req,
  input wire asr_pkg::asr_fdd_t fdd_req,
  // Lines into the block
  output var asr_pkg::asr_src_t src,
  output var asr_pkg::asr_fdd_t fdd
);
  // Requests persist until removed at the source, as real peripherals do
  always_ff @(posedge core_clk) begin
    src <= src_req;
    fdd <= fdd_req;
  end
endmodule
`default_nettype wire

// *** sim/test_asr_regs.sv ***
`timescale 1ns/10ps
`default_nettype none
module test_asr_regs;
  logic core_clk = 1'b0;
  logic rst_b = 1'b0;
  asr_pkg::asr_bus_t bus = '0;
  asr_pkg::asr_shd_t shd = '0;
  asr_pkg::asr_src_t src_req = '0;
  asr_pkg::asr_src_t src;
  asr_pkg::asr_fdd_t fdd_req = 4'he;
  asr_pkg::asr_fdd_t fdd;
  logic serial_two_rx = 1'b1;
  logic alt_infrared_rx = 1'b1;
  logic ir_location_mux = 1'b0;
  logic [7:0] rdata;
  logic [7:0] v;
  logic [4:0] pin_mux_sel;
  logic disk_changed_bit;
  logic irq;
  int num_errors = 0;
  int num_checks = 0;
  // Source levels, status one, status two without the edge bit
  logic [23:0] rows [10] = '{24'h800200, 24'h400400, 24'h200800, 24'h101000, 24'h088000,
    24'h040001, 24'h020002, 24'h010010, 24'hff9e13, 24'h000000};
  always #50 core_clk = ~core_clk;
  asr_periph peer (.core_clk(core_clk), .src_req(src_req), .fdd_req(fdd_req), .src(src),
    .fdd(fdd));
  asr_regs uut (.core_clk(core_clk), .rst_b(rst_b), .bus(bus), .rdata(rdata), .src(src),
    .shd(shd), .serial_two_rx(serial_two_rx), .alt_infrared_rx(alt_infrared_rx),
    .ir_location_mux(ir_location_mux), .fdd(fdd), .disk_changed_bit(disk_changed_bit),
    .pin_mux_sel(pin_mux_sel), .irq(irq));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk);
    bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge core_clk);
    bus.wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge core_clk);
    bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge core_clk);
    bus.rd <= 1'b0;
    #1 v = rdata;
  endtask
  // Pins pass a two-flop chain, so allow a settling margin
  task automatic pins(input logic [3:0] f, input logic s2, input logic alt);
    @(posedge core_clk);
    fdd_req <= f;
    serial_two_rx <= s2;
    alt_infrared_rx <= alt;
    repeat (6) @(posedge core_clk);
  endtask
  task automatic print_verdict;
    if (num_errors == 0 && num_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (3000) @(posedge core_clk);
    num_errors++;
    print_verdict();
  end
  initial begin
    repeat (12) @(posedge core_clk);
    rst_b <= 1'b1;
    chk("pin_mux_sel", {3'b000, pin_mux_sel}, 8'h06);
    rd(8'hc1);
    chk("force", v, 8'h03);
    for (int i = 0; i < 10; i++) begin
      @(posedge core_clk);
      src_req <= rows[i][23:16];
      repeat (3) @(posedge core_clk);
      wr(8'hb6, 8'hff);
      wr(8'hb7, 8'hff);
      rd(8'hb6);
      chk("stat_one", v, rows[i][15:8]);
      rd(8'hb7);
      chk("stat_two", v & 8'hfb, rows[i][7:0]);
    end
    wr(8'hc0, 8'hff);
    rd(8'hc0);
    chk("mux", v, 8'h1f);
    chk("pin_mux_sel", {3'b000, pin_mux_sel}, 8'h1f);
    for (int i = 0; i < 3; i++) begin
      @(posedge core_clk);
      shd <= {i == 0, i == 1, i == 2, 8'hff};
      @(posedge core_clk);
      shd <= '0;
      // Read straight after the capture, then check that a bus write is ignored
      rd(8'hc2 + 8'(i));
      chk("shadow", v, (i == 0) ? 8'hdf : 8'hcf);
      wr(8'hc2 + 8'(i), 8'h00);
      rd(8'hc2 + 8'(i));
      chk("shadow", v, (i == 0) ? 8'hdf : 8'hcf);
    end
    wr(8'hb8, 8'hff);
    rd(8'hb8);
    chk("rsvd", v, 8'h00);
    rd(8'h55);
    chk("unmapped", v, 8'h00);
    pins(4'h2, 1'b1, 1'b1);
    rd(8'hc1);
    chk("force", v, 8'h02);
    pins(4'hc, 1'b1, 1'b1);
    chk("disk_changed_bit", {7'h00, disk_changed_bit}, 8'h00);
    pins(4'h4, 1'b1, 1'b1);
    rd(8'hc1);
    chk("force", v, 8'h00);
    pins(4'hf, 1'b1, 1'b1);
    chk("disk_changed_bit", {7'h00, disk_changed_bit}, 8'h01);
    pins(4'he, 1'b1, 1'b1);
    wr(8'hc1, 8'h00);
    rd(8'hc1);
    chk("force", v, 8'h00);
    wr(8'hc1, 8'h01);
    rd(8'hc1);
    chk("force", v, 8'h01);
    chk("disk_changed_bit", {7'h00, disk_changed_bit}, 8'h01);
    wr(8'hc1, 8'h02);
    rd(8'hc1);
    chk("force", v, 8'h03);
    wr(8'hd1, 8'h00);
    // Both forced flags were cleared by steps, no infrared edge yet
    rd(8'hd0);
    chk("ist", v, 8'h06);
    wr(8'hd0, 8'h07);
    rd(8'hb7);
    pins(4'he, 1'b0, 1'b1);
    rd(8'hb7);
    chk("ir_edge", v & 8'h04, 8'h04);
    rd(8'hb7);
    chk("ir_edge", v & 8'h04, 8'h00);
    chk("irq", {7'h00, irq}, 8'h00);
    pins(4'he, 1'b0, 1'b0);
    @(posedge core_clk);
    ir_location_mux <= 1'b1;
    rd(8'hb7);
    pins(4'he, 1'b1, 1'b0);
    rd(8'hb7);
    chk("ir_edge", v & 8'h04, 8'h00);
    pins(4'he, 1'b1, 1'b1);
    rd(8'hb7);
    chk("ir_edge", v & 8'h04, 8'h04);
    wr(8'hd1, 8'h01);
    rd(8'hd0);
    chk("irq", {7'h00, irq}, 8'h01);
    wr(8'hd0, 8'h07);
    rd(8'hd0);
    chk("irq", {7'h00, irq}, 8'h00);
    // Mid-run reset: leave non-default state behind first
    pins(4'h2, 1'b1, 1'b1);
    pins(4'he, 1'b1, 1'b1);
    rd(8'hc1);
    chk("force", v, 8'h02);
    @(posedge core_clk);
    rst_b <= 1'b0;
    repeat (2) @(posedge core_clk);
    rst_b <= 1'b1;
    chk("pin_mux_sel", {3'b000, pin_mux_sel}, 8'h06);
    chk("irq", {7'h00, irq}, 8'h00);
    rd(8'hc1);
    chk("force", v, 8'h03);
    rd(8'hc0);
    chk("mux", v, 8'h06);
    print_verdict();
  end
endmodule
`default_nettype wire
